// file: include/tws_params.svh
/*
 * Register offsets, field positions, reset values, status codes and
 * the last bit slot index for the two-wire master sequencer.
 * Assumes a 40 MHz mclk and a 32-bit APB slave port with byte addresses.
 */
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// Register byte offsets
`define TWS_OFS_CTRL 8'h00
`define TWS_OFS_STATUS 8'h04
`define TWS_OFS_DATA 8'h08
`define TWS_OFS_RATE 8'h0C

// Control register fields
`define TWS_CB_IRQ 7
`define TWS_CB_ACK 6
`define TWS_CB_START 5
`define TWS_CB_STOP 4
`define TWS_CB_WCOL 3
`define TWS_CB_EN 2

// Reset values
`define TWS_RATE_RST 8'h0A
`define TWS_DATA_RST 8'hFF

// Bus status codes, low three bits always zero
`define TWS_ST_START 8'h08
`define TWS_ST_RSTART 8'h10
`define TWS_ST_TX_AACK 8'h18
`define TWS_ST_TX_ANACK 8'h20
`define TWS_ST_TX_DACK 8'h28
`define TWS_ST_TX_DNACK 8'h30
`define TWS_ST_ARB_LOST 8'h38
`define TWS_ST_RX_AACK 8'h40
`define TWS_ST_RX_ANACK 8'h48
`define TWS_ST_RX_DACK 8'h50
`define TWS_ST_RX_DNACK 8'h58
`define TWS_ST_IDLE 8'hF8

// Index of the last of the nine bit slots in one byte frame, data plus acknowledge
`define TWS_LAST_BIT 4'h8

`endif

// file: include/tws_pkg.sv
/*
 * Types shared by the two-wire master sequencer files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tws_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_WAIT_FREE, S_START_HI, S_START_LO, S_HOLD, S_RESTART,
        S_BIT_LO, S_BIT_HI, S_STOP_LO, S_STOP_HI, S_STOP_END
    } tws_state_t;

    // Clock and data line levels travel together
    typedef struct packed {
        logic scl;
        logic sda;
    } tws_pins_t;
endpackage

// file: rtl/tws_master.sv
/*
 * Two-wire bus master sequencer: START, address and data bytes in both
 * directions, acknowledge handling, arbitration loss, STOP, and an APB
 * register file with control, status, data and bit-rate registers.
 * Assumes open-drain pads outside and a zero-wait APB master on mclk.
 */
// Notes on behaviour
// - Acked transmitted data byte reports 0x28
// - Not-acked transmitted data byte reports 0x30
// - Flag clear with no requests sends byte
// - Start sends repeated START; both stop then start
// - STOP sent, then stop request self-clears
// - Arbitration loss reports 0x38, releases bus
// - START waits for free bus, reports 0x08
// - Address direction bit picks transmit or receive
// - Read address outcome reports 0x38, 0x40, 0x48
// - Received byte readable when flag sets
// - Repeated START reports 0x10, keeps bus
// - Read address sent after flag clear
// - Prescaler bits of status read zero
// - Transfer suspended while flag stays set
// - Data write with flag low sets collision
// - Ack enable picks receive acknowledge response
`include "tws_params.svh"

module tws_master (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus lines, open drain
    input wire tws_pkg::tws_pins_t pinsIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe
);
    import tws_pkg::*;

    tws_state_t state;
    tws_pins_t lvl;
    logic busBusy;
    logic [7:0] tmr;
    logic half;
    logic [3:0] bitCnt;
    logic [8:0] txShift;
    logic [8:0] rxShift;
    logic own;
    logic isAddr;
    logic isRead;
    logic irqFlag;
    logic [7:0] statusCode;
    logic ifaceEnable;
    logic ackEnable;
    logic startReq;
    logic stopReq;
    logic wcol;
    logic [7:0] dataReg;
    logic [7:0] rateReg;

    tws_pin_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .pinsRaw(pinsIn),
        .pinsLvl(lvl),
        .busBusy(busBusy)
    );

    // APB decode; every access completes in its first access cycle
    wire access = psel && penable && pready;
    wire selCtrl = (paddr == `TWS_OFS_CTRL);
    wire selStat = (paddr == `TWS_OFS_STATUS);
    wire selData = (paddr == `TWS_OFS_DATA);
    wire selRate = (paddr == `TWS_OFS_RATE);
    wire mapped = selCtrl || selStat || selData || selRate;
    wire ctrlWr = access && pwrite && selCtrl;
    wire dataWr = access && pwrite && selData;
    wire rateWr = access && pwrite && selRate;
    wire swClear = ctrlWr && pwdata[`TWS_CB_IRQ];
    wire [7:0] ctrlView = {irqFlag, ackEnable, startReq, stopReq, wcol, ifaceEnable, 2'h0};
    wire [7:0] statView = {statusCode[7:3], 3'h0};
    wire [7:0] readMux;
    assign readMux = selCtrl ? ctrlView :
                     selStat ? statView :
                     selData ? dataReg :
                     selRate ? rateReg : 8'h00;

    // Bit engine conditions
    wire tmrZero = (tmr == 8'h00);
    wire bitEnd = (state == S_BIT_HI) && lvl.scl && tmrZero;
    wire lastBit = (bitCnt == `TWS_LAST_BIT);
    // A released one read back as zero means another master won
    wire arbLost = bitEnd && !lastBit && !sdaOe && !lvl.sda && (isAddr || !isRead);
    wire byteEnd = bitEnd && lastBit;
    wire ackOk = !lvl.sda;
    wire stopDone = (state == S_STOP_END) && tmrZero;
    wire launch = (state == S_HOLD) && !irqFlag && !stopReq && !startReq;
    wire [7:0] addrCode = dataReg[0] ? (ackOk ? `TWS_ST_RX_AACK : `TWS_ST_RX_ANACK)
                                     : (ackOk ? `TWS_ST_TX_AACK : `TWS_ST_TX_ANACK);
    wire [7:0] dataCode = isRead ? (ackOk ? `TWS_ST_RX_DACK : `TWS_ST_RX_DNACK)
                                 : (ackOk ? `TWS_ST_TX_DACK : `TWS_ST_TX_DNACK);
    wire [7:0] nextCode = isAddr ? addrCode : dataCode;
    // Receive data drives the chosen acknowledge, everything else sends the data register
    wire [8:0] launchBits = (isRead && !isAddr) ? {8'hFF, !ackEnable} : {dataReg, 1'h1};

    // APB answer registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            prdata <= {24'h00_0000, readMux};
            pslverr <= psel && !penable && !mapped;
        end
    end

    // Pad data levels stay low; only the enables move the lines
    always_ff @(posedge mclk) begin
        sclOut <= 1'b0;
        sdaOut <= 1'b0;
    end

    // Control bits; a software write of stop wins over the self clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ifaceEnable <= 1'b0;
            ackEnable <= 1'b0;
            startReq <= 1'b0;
            stopReq <= 1'b0;
            rateReg <= `TWS_RATE_RST;
        end else begin
            if (ctrlWr) begin
                ifaceEnable <= pwdata[`TWS_CB_EN];
                ackEnable <= pwdata[`TWS_CB_ACK];
                startReq <= pwdata[`TWS_CB_START];
                stopReq <= pwdata[`TWS_CB_STOP];
            end else if (stopDone) begin
                stopReq <= 1'b0;
            end
            if (rateWr) rateReg <= pwdata[7:0];
        end
    end

    // Data register: received byte on frame end, software only while suspended
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dataReg <= `TWS_DATA_RST;
            wcol <= 1'b0;
        end else begin
            if (byteEnd && isRead && !isAddr) dataReg <= rxShift[7:0];
            else if (dataWr && irqFlag) dataReg <= pwdata[7:0];
            if (dataWr && !irqFlag) wcol <= 1'b1;
            else if (dataWr) wcol <= 1'b0;
        end
    end

    // Sequencer; each phase lasts rateReg+1 cycles, a bit low phase twice that, and the bit and STOP high
    // phases count only once the clock line reads high, so slaves may stretch it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= S_IDLE;
            tmr <= 8'h00;
            half <= 1'b0;
            bitCnt <= 4'h0;
            txShift <= 9'h1FF;
            rxShift <= 9'h000;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
            own <= 1'b0;
            isAddr <= 1'b0;
            isRead <= 1'b0;
            irqFlag <= 1'b0;
            statusCode <= `TWS_ST_IDLE;
        end else begin
            if (!tmrZero) tmr <= tmr - 8'h01;
            // Later sets in this block override the software clear
            if (swClear) irqFlag <= 1'b0;
            if (!ifaceEnable) begin
                state <= S_IDLE;
                sclOe <= 1'b0;
                sdaOe <= 1'b0;
                own <= 1'b0;
            end else begin
                case (state)
                    S_IDLE: begin
                        sclOe <= 1'b0;
                        sdaOe <= 1'b0;
                        if (!irqFlag && startReq) begin
                            state <= S_WAIT_FREE;
                            tmr <= rateReg;
                        end
                    end
                    S_WAIT_FREE: begin
                        if (!lvl.scl || (busBusy && !own)) begin
                            tmr <= rateReg;
                        end else if (tmrZero) begin
                            sdaOe <= 1'b1;
                            state <= S_START_HI;
                            tmr <= rateReg;
                        end
                    end
                    S_START_HI: begin
                        if (tmrZero) begin
                            sclOe <= 1'b1;
                            state <= S_START_LO;
                            tmr <= rateReg;
                        end
                    end
                    S_START_LO: begin
                        if (tmrZero) begin
                            statusCode <= own ? `TWS_ST_RSTART : `TWS_ST_START;
                            own <= 1'b1;
                            isAddr <= 1'b1;
                            irqFlag <= 1'b1;
                            state <= S_HOLD;
                        end
                    end
                    S_HOLD: begin
                        // Clock held low until software clears the flag
                        if (!irqFlag) begin
                            if (stopReq) begin
                                sdaOe <= 1'b1;
                                state <= S_STOP_LO;
                                tmr <= rateReg;
                            end else if (startReq) begin
                                sdaOe <= 1'b0;
                                state <= S_RESTART;
                                tmr <= rateReg;
                            end else begin
                                txShift <= launchBits;
                                bitCnt <= 4'h0;
                                half <= 1'b0;
                                state <= S_BIT_LO;
                                tmr <= rateReg;
                            end
                        end
                    end
                    S_RESTART: begin
                        if (tmrZero) begin
                            sclOe <= 1'b0;
                            state <= S_WAIT_FREE;
                            tmr <= rateReg;
                        end
                    end
                    S_BIT_LO: begin
                        // Data changes mid low phase, clear of both clock edges
                        if (tmrZero && !half) begin
                            sdaOe <= !txShift[8];
                            half <= 1'b1;
                            tmr <= rateReg;
                        end else if (tmrZero) begin
                            half <= 1'b0;
                            sclOe <= 1'b0;
                            state <= S_BIT_HI;
                            tmr <= rateReg;
                        end
                    end
                    S_BIT_HI: begin
                        if (!lvl.scl) begin
                            tmr <= rateReg;
                        end else if (tmrZero) begin
                            rxShift <= {rxShift[7:0], lvl.sda};
                            if (arbLost) begin
                                sclOe <= 1'b0;
                                sdaOe <= 1'b0;
                                own <= 1'b0;
                                statusCode <= `TWS_ST_ARB_LOST;
                                irqFlag <= 1'b1;
                                state <= S_IDLE;
                            end else if (lastBit) begin
                                sclOe <= 1'b1;
                                statusCode <= nextCode;
                                irqFlag <= 1'b1;
                                isAddr <= 1'b0;
                                if (isAddr) isRead <= dataReg[0];
                                state <= S_HOLD;
                            end else begin
                                sclOe <= 1'b1;
                                txShift <= {txShift[7:0], 1'h1};
                                bitCnt <= bitCnt + 4'h1;
                                state <= S_BIT_LO;
                                tmr <= rateReg;
                            end
                        end
                    end
                    S_STOP_LO: begin
                        if (tmrZero) begin
                            sclOe <= 1'b0;
                            state <= S_STOP_HI;
                            tmr <= rateReg;
                        end
                    end
                    S_STOP_HI: begin
                        if (!lvl.scl) begin
                            tmr <= rateReg;
                        end else if (tmrZero) begin
                            sdaOe <= 1'b0;
                            state <= S_STOP_END;
                            tmr <= rateReg;
                        end
                    end
                    S_STOP_END: begin
                        if (tmrZero) begin
                            own <= 1'b0;
                            statusCode <= `TWS_ST_IDLE;
                            state <= S_IDLE;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    default clocking cbChk @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_tx_ack_code: assert property (
        (byteEnd && ifaceEnable && !isAddr && !isRead && ackOk)
        |=> irqFlag && statusCode == `TWS_ST_TX_DACK && state == S_HOLD)
        else $error("acked data byte did not report 0x28");
    a_tx_nack_code: assert property (
        (byteEnd && ifaceEnable && !isAddr && !isRead && !ackOk)
        |=> irqFlag && statusCode == `TWS_ST_TX_DNACK)
        else $error("not-acked data byte did not report 0x30");
    a_byte_launch: assert property (
        (launch && ifaceEnable) |=> state == S_BIT_LO && bitCnt == 4'h0 ##1 sclOe)
        else $error("flag clear did not start a byte");
    a_stop_clear: assert property (
        (stopDone && ifaceEnable && !ctrlWr) |=> !stopReq && state == S_IDLE && !sdaOe)
        else $error("stop request not cleared after STOP");
    a_arb_release: assert property (
        (arbLost && ifaceEnable) |=> statusCode == `TWS_ST_ARB_LOST && irqFlag && !sclOe && !own)
        else $error("arbitration loss not reported");
    a_start_code: assert property (
        (state == S_START_LO && tmrZero && !own && ifaceEnable)
        |=> statusCode == `TWS_ST_START && irqFlag && own && sclOe)
        else $error("START did not report 0x08");
    a_rstart_code: assert property (
        (state == S_START_LO && tmrZero && own && ifaceEnable)
        |=> statusCode == `TWS_ST_RSTART && own)
        else $error("repeated START did not report 0x10");
    a_addr_dir: assert property (
        (byteEnd && isAddr && ifaceEnable) |=> isRead == $past(dataReg[0]) && !isAddr)
        else $error("direction not taken from address");
    a_rx_data: assert property (
        (byteEnd && isRead && !isAddr && ifaceEnable)
        |=> dataReg == $past(rxShift[7:0]) && irqFlag)
        else $error("received byte not in data register");
    a_hold_stall: assert property (
        (state == S_HOLD && irqFlag && ifaceEnable && !swClear) |=> state == S_HOLD && sclOe)
        else $error("transfer moved while flag set");
    a_wcol_set: assert property (
        (dataWr && !irqFlag && !byteEnd) |=> wcol && $stable(dataReg))
        else $error("collision write not discarded");
    a_ack_choice: assert property (
        (launch && ifaceEnable && isRead && !isAddr) |=> txShift[0] == !$past(ackEnable))
        else $error("receive acknowledge ignores ack enable");
endmodule

// file: rtl/tws_pin_sync.sv
/*
 * Three-flop synchronisers with agreement filter for both bus lines,
 * plus bus-busy tracking from START and STOP conditions.
 * Assumes the lines are pulled high outside and sampled on mclk.
 */
module tws_pin_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Raw pins and filtered levels
    input tws_pkg::tws_pins_t pinsRaw,
    output tws_pkg::tws_pins_t pinsLvl,
    output logic busBusy
);
    import tws_pkg::*;

    logic [1:0] rawVec;
    logic [1:0] lvlVec;
    logic [1:0] prevVec;
    wire startSeen;
    wire stopSeen;

    assign rawVec = pinsRaw;
    assign pinsLvl = lvlVec;

    // One synchroniser per line; only the second and third flops are compared
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_line
            logic [2:0] sh;
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    sh <= 3'h7;
                    lvlVec[i] <= 1'b1;
                end else begin
                    sh <= {sh[1:0], rawVec[i]};
                    if (sh[1] == sh[2]) lvlVec[i] <= sh[2];
                end
            end
        end
    endgenerate

    // Data edges while the clock line stays high mark START and STOP
    assign startSeen = lvlVec[1] && prevVec[1] && prevVec[0] && !lvlVec[0];
    assign stopSeen = lvlVec[1] && prevVec[1] && !prevVec[0] && lvlVec[0];

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prevVec <= 2'h3;
            busBusy <= 1'b0;
        end else begin
            prevVec <= lvlVec;
            if (startSeen) busBusy <= 1'b1;
            else if (stopSeen) busBusy <= 1'b0;
        end
    end
endmodule

// file: test/tb_top.sv
/*
 * Self-checking bench for the two-wire master sequencer: APB tasks and
 * register call sequences against one behavioural slave.
 * Assumes the design answers APB without a fixed latency promise.
 */
`include "tws_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tws_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sclOe, sdaOe, sdaPull, rerr, sclOut, sdaOut;
    logic nackAll = 1'b0;
    logic arbLose = 1'b0;
    logic [31:0] rdata;
    wire tws_pkg::tws_pins_t pins;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    // Wired-AND lines; the slave never stretches the clock
    assign pins = {!sclOe, !(sdaOe || sdaPull)};
    always #12.5 mclk = !mclk;
    tws_master DUT (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pinsIn(pins), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
        .sdaOe(sdaOe));
    tws_slave_model slv (.scl(pins.scl), .sda(pins.sda), .nackAll(nackAll),
        .arbLose(arbLose), .txByte(8'hC3), .sdaPull(sdaPull));
    // Hang guard, far above the longest sequence
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; an edge passes after release so setups never collide
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Ends when pready reads high; the hang guard ends the test if it never does
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    // Control write, wait for the flag, compare the status code
    task automatic step(input logic [7:0] c, input logic [7:0] code);
        apb(1'b1, `TWS_OFS_CTRL, {24'h0, c});
        do begin
            apb(1'b0, `TWS_OFS_CTRL, 32'h0);
        end while (rdata[`TWS_CB_IRQ] !== 1'b1);
        apb(1'b0, `TWS_OFS_STATUS, 32'h0);
        chk("status", rdata, {24'h0, code});
    endtask
    // Wait for idle after a STOP, then look at the stop request bit
    task automatic idle();
        logic [31:0] s;
        do begin
            apb(1'b0, `TWS_OFS_STATUS, 32'h0);
        end while (rdata[7:0] !== `TWS_ST_IDLE);
        s = rdata;
        apb(1'b0, `TWS_OFS_CTRL, 32'h0);
        chk("idle status", s, {24'h0, `TWS_ST_IDLE});
        chk("stop bit", {31'h0, rdata[`TWS_CB_STOP]}, 32'h0);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rdata, exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd_chk("status rst", `TWS_OFS_STATUS, {24'h0, `TWS_ST_IDLE});
        rd_chk("ctrl rst", `TWS_OFS_CTRL, 32'h0);
        rd_chk("data rst", `TWS_OFS_DATA, {24'h0, `TWS_DATA_RST});
        rd_chk("rate rst", `TWS_OFS_RATE, {24'h0, `TWS_RATE_RST});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", {31'h0, rerr}, 32'h1);
        apb(1'b1, `TWS_OFS_RATE, 32'h3); // Phases of four mclk cycles
        apb(1'b1, `TWS_OFS_DATA, 32'h11);
        rd_chk("collision", `TWS_OFS_CTRL, 32'h8);
        $display("test reset and collision done");
        step(8'hA4, `TWS_ST_START);
        apb(1'b1, `TWS_OFS_DATA, 32'hA0);
        step(8'h84, `TWS_ST_TX_AACK);
        apb(1'b1, `TWS_OFS_DATA, 32'h5A);
        step(8'h84, `TWS_ST_TX_DACK);
        chk("slave byte", {24'h0, slv.sh}, 32'h5A);
        repeat (40) @(posedge mclk);
        chk("scl held", {31'h0, sclOe}, 32'h1);
        chk("pad levels", {30'h0, sclOut, sdaOut}, 32'h0);
        nackAll <= 1'b1;
        apb(1'b1, `TWS_OFS_DATA, 32'h33);
        step(8'h84, `TWS_ST_TX_DNACK);
        nackAll <= 1'b0;
        $display("test transmit done");
        step(8'hA4, `TWS_ST_RSTART);
        apb(1'b1, `TWS_OFS_DATA, 32'hA1);
        step(8'h84, `TWS_ST_RX_AACK);
        step(8'hC4, `TWS_ST_RX_DACK);
        rd_chk("rx byte", `TWS_OFS_DATA, 32'hC3);
        step(8'h84, `TWS_ST_RX_DNACK);
        rd_chk("last byte", `TWS_OFS_DATA, 32'hC3);
        step(8'hB4, `TWS_ST_START);
        nackAll <= 1'b1;
        apb(1'b1, `TWS_OFS_DATA, 32'hA1);
        step(8'h84, `TWS_ST_RX_ANACK);
        nackAll <= 1'b0;
        apb(1'b1, `TWS_OFS_CTRL, 32'h94);
        idle();
        $display("test receive done");
        step(8'hA4, `TWS_ST_START);
        apb(1'b1, `TWS_OFS_DATA, 32'hA0);
        step(8'h84, `TWS_ST_TX_AACK);
        arbLose <= 1'b1;
        apb(1'b1, `TWS_OFS_DATA, 32'hFF);
        step(8'h84, `TWS_ST_ARB_LOST);
        chk("sda released", {31'h0, sdaOe}, 32'h0);
        chk("scl released", {31'h0, sclOe}, 32'h0);
        arbLose <= 1'b0;
        step(8'hA4, `TWS_ST_START);
        apb(1'b1, `TWS_OFS_CTRL, 32'h94);
        idle();
        $display("test arbitration done");
        end_of_test();
    end
endmodule

// file: test/tws_slave_model.sv
/*
 * Behavioural two-wire slave for the master sequencer bench.
 * Assumes the bench resolves both lines as wired-AND with pull-ups.
 */
module tws_slave_model (
    // Resolved bus lines
    input wire logic scl,
    input wire logic sda,
    // Bench knobs
    input wire logic nackAll,
    input wire logic arbLose,
    input wire logic [7:0] txByte,
    // Open-drain data pull
    output logic sdaPull
);
    timeunit 1ns;
    timeprecision 100ps;
    int bitCnt = 0;
    logic [7:0] sh = 8'h00;
    logic first = 1'b0;
    logic reading = 1'b0;
    logic mNack = 1'b0;
    logic drv = 1'b0;
    // A forced clash pulls data low regardless of framing
    assign sdaPull = drv || arbLose;
    // START or repeated START restarts framing
    always @(negedge sda) if (scl) begin
        bitCnt = 0;
        first = 1'b1;
        reading = 1'b0;
        drv = 1'b0;
    end
    // Ninth slot carries the master's acknowledge
    always @(posedge scl) begin
        if (bitCnt < 8) sh = {sh[6:0], sda};
        else mNack = sda;
        bitCnt++;
    end
    // Change data only while the clock is low
    always @(negedge scl) begin
        if (bitCnt == 9) begin
            bitCnt = 0;
            if (mNack && !first) reading = 1'b0; // Stop sending after a refusal
            first = 1'b0;
        end
        if (bitCnt == 8) begin
            if (first) reading = sh[0] && !nackAll;
            drv = (first || !reading) && !nackAll;
        end else begin
            drv = reading && !first && bitCnt < 8 && !txByte[7 - bitCnt];
        end
    end
endmodule
